/* core/ibp_bank.sv */
// Functional notes
// - After poll, status read returns code of highest-priority requesting level.
// - Status shows pending requests or in-service levels per readback selection.
// - Read-only mask readback mirrors the last mask command word.
// - Each input has a read/write vector, driven out on acknowledge.
// - Init is two to four writes; third and fourth only if word one asks.
// - Init word two write raises alert level; readback of word two clears it.
// - Init word one resets edge detection; in edge mode a fresh fall is then needed.
// - Init word one clears the mask register.
// - Init word one gives the last input lowest priority, seven.
// - Init word one exits special mask and selects pending readback.
// - Without a fourth word, auto end of service stays off.
// - Control words are accepted any time, in any order.
// - Poll and readback selected together: poll wins.
// - Readback selection persists; poll applies to one read only.
// - Status read after poll acts as acknowledge, pending unchanged.
// - Special mask select acts only when special mask enable is set.
// - Request pins are active low and inverted into pending bits.
// - Words are told apart by offset, write order and identifying bits.
// - Word one selects trigger mode, cascade (third word) and fourth word.
// - Word four selects auto end of service and special nested mode.
`default_nettype none
module ibp_bank (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    input  wire logic [3:0] addr_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    input  wire logic [7:0] wr_data_i,
    input  wire logic [7:0] req_n_i,
    input  wire logic       ack_i,
    input  wire logic       alert_set_i,
    input  wire logic       alert_clr_i,
    output logic      [7:0] rd_data_o,
    output logic            int_o,
    output logic            init_alert_o,
    output logic            w2_written_o,
    output logic            w2_read_o,
    output logic            init_done_o,
    output logic            level_mode_o,
    output logic            auto_eoi_o,
    output logic            nested_o,
    output logic            special_mask_o,
    output logic      [7:0] cascade_o,
    output logic      [2:0] lowest_prio_o
);
    // ==================================================
    // Address and command-word decode
    wire is_cmd   = (addr_i == ibp_pkg::OFS_CMD);
    wire is_data  = (addr_i == ibp_pkg::OFS_DATA);
    wire is_w2rd  = (addr_i == ibp_pkg::OFS_W2_READ);
    wire is_vec   = addr_i[3];
    // Offset, order and identifying bits pick the target word
    wire wr_w1    = wr_i & is_cmd & wr_data_i[ibp_pkg::BIT_W1_ID];
    wire wr_c3    = wr_i & is_cmd & ~wr_data_i[ibp_pkg::BIT_W1_ID]
                  & wr_data_i[ibp_pkg::BIT_CONTROL_WORD_THREE_ID];
    wire wr_c2    = wr_i & is_cmd & ~wr_data_i[ibp_pkg::BIT_W1_ID]
                  & ~wr_data_i[ibp_pkg::BIT_CONTROL_WORD_THREE_ID];
    wire wr_dat   = wr_i & is_data;
    wire rd_stat  = rd_i & is_cmd;
    wire rd_w2    = rd_i & is_w2rd;
    // Writes to offset 2 match nothing

    // ==================================================
    // Init sequencer
    // Word one notes which words follow
    // Data writes then step through them
    ibp_pkg::ibp_seq_e seq_q;
    ibp_pkg::ibp_seq_e seq_d;
    logic need_w3_q;
    logic need_w4_q;
    logic done_q;

    // Sequencer state names the data word
    wire wr_w2   = wr_dat & (seq_q == ibp_pkg::ST_WAIT_W2);
    wire wr_w3   = wr_dat & (seq_q == ibp_pkg::ST_WAIT_W3);
    wire wr_w4   = wr_dat & (seq_q == ibp_pkg::ST_WAIT_W4);
    // Mask word only once the sequence is through
    wire wr_mask = wr_dat & (seq_q == ibp_pkg::ST_READY);

    // Next state; word one restarts from any state
    // Data writes in READY are mask words
    always_comb begin
        seq_d = seq_q;
        if (wr_w1) begin
            seq_d = ibp_pkg::ST_WAIT_W2;
        end else begin
            case (seq_q)
                ibp_pkg::ST_READY: begin
                    seq_d = ibp_pkg::ST_READY;
                end
                ibp_pkg::ST_WAIT_W2: begin
                    if (wr_dat) begin
                        seq_d = need_w3_q ? ibp_pkg::ST_WAIT_W3 :
                                need_w4_q ? ibp_pkg::ST_WAIT_W4 :
                                ibp_pkg::ST_READY;
                    end
                end
                ibp_pkg::ST_WAIT_W3: begin
                    if (wr_dat) begin
                        seq_d = need_w4_q ? ibp_pkg::ST_WAIT_W4 : ibp_pkg::ST_READY;
                    end
                end
                ibp_pkg::ST_WAIT_W4: begin
                    if (wr_dat) begin
                        seq_d = ibp_pkg::ST_READY;
                    end
                end
                default: begin
                    seq_d = ibp_pkg::ST_READY;
                end
            endcase
        end
    end

    // Sequencer state and the choices word one makes
    // Word-one flags hold until next word one
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            seq_q     <= ibp_pkg::ST_READY;
            need_w3_q <= 1'b0;
            need_w4_q <= 1'b0;
            done_q    <= 1'b0;
        end else begin
            seq_q <= seq_d;
            if (wr_w1) begin
                need_w3_q <= ~wr_data_i[ibp_pkg::BIT_W1_SINGLE];
                need_w4_q <= wr_data_i[ibp_pkg::BIT_W1_W4];
            end
            // Set on the step into READY only
            done_q <= ~wr_w1 & (done_q | ((seq_q != ibp_pkg::ST_READY)
                    & (seq_d == ibp_pkg::ST_READY)));
        end
    end

    // ==================================================
    // Mode registers
    // Bytes kept for readback and ports
    logic [7:0] mask_q;
    logic [7:0] w2_q;
    logic [7:0] casc_q;
    logic       level_q;
    logic       auto_end_of_service_q;
    logic       special_nested_select_q;
    logic       smm_q;
    logic       ris_q;
    logic       poll_q;
    logic [2:0] lowest_q;

    // Init words and control words; word one forces the defaults
    // Word one outranks any other write,
    // so its defaults always apply whole
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mask_q   <= ibp_pkg::RST_MASK;
            w2_q     <= ibp_pkg::RST_BYTE;
            casc_q   <= ibp_pkg::RST_BYTE;
            level_q  <= 1'b0;
            auto_end_of_service_q   <= 1'b0;
            special_nested_select_q   <= 1'b0;
            smm_q    <= 1'b0;
            ris_q    <= 1'b0;
            lowest_q <= ibp_pkg::LOWEST_PRIO_INPUT;
        end else if (wr_w1) begin
            mask_q   <= ibp_pkg::RST_MASK;
            lowest_q <= ibp_pkg::LOWEST_PRIO_INPUT;
            smm_q    <= 1'b0;
            ris_q    <= 1'b0;
            level_q  <= wr_data_i[ibp_pkg::BIT_W1_LEVEL];
            auto_end_of_service_q   <= 1'b0;
            special_nested_select_q   <= 1'b0;
            casc_q   <= ibp_pkg::RST_BYTE;
        end else begin
            if (wr_w2) begin
                w2_q <= wr_data_i;
            end
            if (wr_w3) begin
                casc_q <= wr_data_i;
            end
            if (wr_w4) begin
                auto_end_of_service_q <= wr_data_i[ibp_pkg::BIT_W4_AUTO];
                special_nested_select_q <= wr_data_i[ibp_pkg::BIT_W4_NESTED];
            end
            if (wr_mask) begin
                mask_q <= wr_data_i;
            end
            // Special mask select counts only with its enable
            if (wr_c3 & wr_data_i[ibp_pkg::BIT_C3_SPECIAL_MASK_ENABLE]) begin
                smm_q <= wr_data_i[ibp_pkg::BIT_C3_SMM];
            end
            // Selection persists until the next readback command or word one
            if (wr_c3 & wr_data_i[ibp_pkg::BIT_C3_RR]) begin
                ris_q <= wr_data_i[ibp_pkg::BIT_C3_RIS];
            end
        end
    end

    // ==================================================
    // Requests, acknowledge and in-service
    // Fixed priority, input 0 highest
    logic [7:0] pend;
    logic [7:0] isr_q;
    logic [7:0] isr_d;
    logic [7:0] vec_rd;

    wire [7:0] eligible = pend & ~mask_q;
    wire [3:0] best     = ibp_pkg::ibp_prio(eligible);
    wire [3:0] top_isr  = ibp_pkg::ibp_prio(isr_q);
    // Poll read is treated as an acknowledge
    // Nothing eligible means nothing taken
    wire       poll_rd  = rd_stat & poll_q;
    wire       take     = (ack_i | poll_rd) & best[3];
    wire [7:0] take_bit = take ? (8'h01 << best[2:0]) : 8'h00;
    // Specific level, else top in-service bit
    wire [7:0] eoi_bit  = ~wr_c2 | ~wr_data_i[ibp_pkg::BIT_C2_EOI] ? 8'h00 :
                          wr_data_i[ibp_pkg::BIT_C2_SL] ? (8'h01 << wr_data_i[2:0]) :
                          top_isr[3] ? (8'h01 << top_isr[2:0]) : 8'h00;
    // Pending bits stay put on a poll; only a real acknowledge takes them
    wire [7:0] ack_bit  = ack_i ? take_bit : 8'h00;

    // Auto end of service leaves the in-service bit clear, except on a poll read
    assign isr_d = wr_w1 ? 8'h00 :
                   ((isr_q & ~eoi_bit) | (auto_end_of_service_q & ~poll_rd ? 8'h00 : take_bit));

    // Pin inversion and edge capture
    ibp_req_detect u_req (
        .ref_clk_i    (ref_clk_i),
        .rst_i        (rst_i),
        .req_n_i      (req_n_i),
        .level_mode_i (level_q),
        .rearm_i      (wr_w1),
        .taken_i      (ack_bit),
        .pending_o    (pend)
    );

    // An acknowledge reads the winning vector
    ibp_vector_file u_vec (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .wr_en_i   (wr_i & is_vec),
        .wr_idx_i  (addr_i[2:0]),
        .wr_data_i (wr_data_i),
        .rd_idx_i  (ack_i ? best[2:0] : addr_i[2:0]),
        .rd_data_o (vec_rd)
    );

    // ==================================================
    // Read data selection
    // Acknowledge outranks a bus read
    wire [7:0] poll_word = {best[3], 4'h0, best[2:0]};
    wire [7:0] stat_word = poll_q ? poll_word :
                           ris_q  ? isr_q : pend;
    wire [7:0] rd_sel    = ack_i          ? vec_rd :
                           rd_stat        ? stat_word :
                           rd_i & is_data ? mask_q :
                           rd_w2          ? w2_q :
                           rd_i & is_vec  ? vec_rd : 8'h00;

    // Poll flag lives for exactly one status read
    wire poll_d = wr_c3 ? wr_data_i[ibp_pkg::BIT_C3_POLL] :
                  (poll_q & ~rd_stat);
    // Alert: set wins over clear
    wire alert_d = wr_w2 | alert_set_i | (init_alert_o & ~rd_w2 & ~alert_clr_i);

    // Status and pulse outputs
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            isr_q        <= 8'h00;
            poll_q       <= 1'b0;
            rd_data_o    <= 8'h00;
            int_o        <= 1'b0;
            init_alert_o <= 1'b0;
            w2_written_o <= 1'b0;
            w2_read_o    <= 1'b0;
        end else begin
            isr_q        <= isr_d;
            poll_q       <= poll_d;
            rd_data_o    <= (rd_i | ack_i) ? rd_sel : rd_data_o;
            // Special mask lets a masked in-service level stop blocking
            int_o        <= |(eligible & ~(smm_q ? (isr_q & ~mask_q) : isr_d));
            init_alert_o <= alert_d;
            w2_written_o <= wr_w2;
            w2_read_o    <= rd_w2;
        end
    end

    // Mode outputs
    // Already flip-flops, so ports stay registered
    assign init_done_o    = done_q;
    assign level_mode_o   = level_q;
    assign auto_eoi_o     = auto_end_of_service_q;
    assign nested_o       = special_nested_select_q;
    assign special_mask_o = smm_q;
    assign cascade_o      = casc_q;
    assign lowest_prio_o  = lowest_q;
endmodule // ibp_bank
`default_nettype wire

/* core/ibp_pkg.sv */
`default_nettype none
package ibp_pkg;
    // ==================================================
    // Bank-local I/O offsets
    localparam logic [3:0] OFS_CMD      = 4'h0; // Init word 1, control words 2 and 3
    localparam logic [3:0] OFS_DATA     = 4'h1; // Init words 2 to 4, mask command word
    localparam logic [3:0] OFS_W2_READ  = 4'h2; // Readback of init word 2
    localparam logic [3:0] OFS_VEC_BASE = 4'h8; // Vector registers 8 to F
    // ==================================================
    // Identifying bits inside command words
    localparam int BIT_W1_ID      = 4; // Set: init word 1 on the command offset
    localparam int BIT_CONTROL_WORD_THREE_ID    = 3; // Set (with bit 4 clear): control word 3
    localparam int BIT_W1_W4      = 0; // Fourth word needed
    localparam int BIT_W1_SINGLE  = 1; // Single bank, no third word
    localparam int BIT_W1_LEVEL   = 3; // Level trigger select
    localparam int BIT_W4_AUTO    = 1; // Auto end of service
    localparam int BIT_W4_NESTED  = 4; // Special nested select
    localparam int BIT_C3_RIS     = 0; // Readback select: 1 in-service, 0 pending
    localparam int BIT_C3_RR      = 1; // Readback enable
    localparam int BIT_C3_POLL    = 2; // Poll command
    localparam int BIT_C3_SMM     = 5; // Special mask select
    localparam int BIT_C3_SPECIAL_MASK_ENABLE    = 6; // Special mask enable
    localparam int BIT_C2_EOI     = 5; // End of service command
    localparam int BIT_C2_SL      = 6; // Specific level
    localparam int BIT_POLL_VALID = 7; // Poll result: a request was found
    // ==================================================
    // Reset values
    localparam logic [7:0] RST_BYTE   = 8'h00;
    localparam logic [7:0] RST_MASK   = 8'h00;
    // Lowest priority input is the last one
    localparam logic [2:0] LOWEST_PRIO_INPUT = 3'h7;

    typedef enum logic [1:0] {
        ST_READY,
        ST_WAIT_W2,
        ST_WAIT_W3,
        ST_WAIT_W4
    } ibp_seq_e;

    // Highest-priority set bit; bit 0 is highest, bit 7 lowest
    function automatic logic [3:0] ibp_prio(input logic [7:0] req);
        logic [3:0] res;
        res = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (req[i]) begin
                res = {1'b1, i[2:0]};
            end
        end
        return res;
    endfunction
endpackage
`default_nettype wire

/* core/ibp_vector_file.sv */
`default_nettype none
module ibp_vector_file (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    input  wire logic       wr_en_i,
    input  wire logic [2:0] wr_idx_i,
    input  wire logic [7:0] wr_data_i,
    input  wire logic [2:0] rd_idx_i,
    output logic      [7:0] rd_data_o
);
    // ==================================================
    // One vector byte per request input
    logic [7:0] vec_q [8];

    // Vector storage, written by the host
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < 8; i++) begin
                vec_q[i] <= ibp_pkg::RST_BYTE;
            end
        end else if (wr_en_i) begin
            vec_q[wr_idx_i] <= wr_data_i;
        end
    end

    // Read port is combinational; the caller registers it
    assign rd_data_o = vec_q[rd_idx_i];
endmodule // ibp_vector_file
`default_nettype wire

/* core/ibp_req_detect.sv */
`default_nettype none
module ibp_req_detect (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    input  wire logic [7:0] req_n_i,
    input  wire logic       level_mode_i,
    input  wire logic       rearm_i,
    input  wire logic [7:0] taken_i,
    output logic      [7:0] pending_o
);
    // ==================================================
    // Pin inversion and edge detection
    logic [7:0] armed_q;
    logic [7:0] armed_d;
    logic [7:0] pend_q;
    logic [7:0] pend_d;
    wire  [7:0] pin_req = ~req_n_i;
    wire  [7:0] fall    = armed_q & pin_req; // Fresh high-to-low seen

    // An input arms only after being seen high, so init needs a new fall
    assign armed_d = rearm_i ? 8'h00 : ((armed_q & ~fall) | req_n_i);
    // Set wins over the clear from an acknowledge
    assign pend_d  = rearm_i      ? 8'h00 :
                     level_mode_i ? pin_req :
                     ((pend_q & ~taken_i) | fall);

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            armed_q <= 8'h00;
            pend_q  <= 8'h00;
        end else begin
            armed_q <= armed_d;
            pend_q  <= pend_d;
        end
    end

    assign pending_o = pend_q;
endmodule // ibp_req_detect
`default_nettype wire

/* test/ibp_bank_sva.sv */
`default_nettype none
// ==================================================
// Port-level checker for one interrupt bank
module ibp_bank_sva (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    input  wire logic [3:0] addr_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    input  wire logic [7:0] wr_data_i,
    input  wire logic       ack_i,
    input  wire logic       alert_set_i,
    input  wire logic [7:0] rd_data_o,
    input  wire logic       init_alert_o,
    input  wire logic       w2_written_o,
    input  wire logic       w2_read_o,
    input  wire logic       init_done_o,
    input  wire logic       level_mode_o,
    input  wire logic       auto_eoi_o,
    input  wire logic       special_mask_o,
    input  wire logic [2:0] lowest_prio_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    // Command decode: word one has bit 4 set, control word three bits 4:3 = 01
    wire logic w1_wr = wr_i && addr_i == ibp_pkg::OFS_CMD && wr_data_i[ibp_pkg::BIT_W1_ID];
    wire logic c3_wr = wr_i && addr_i == ibp_pkg::OFS_CMD && wr_data_i[4:3] == 2'b01;
    wire logic w2_rd = rd_i && addr_i == ibp_pkg::OFS_W2_READ && !wr_i && !alert_set_i;

    // ==================================================
    // Word one side effects
    w1_smm_a: assert property (w1_wr |=> !special_mask_o)
        else $error("special mask survived word one");
    w1_prio_a: assert property (w1_wr |-> ##1 (lowest_prio_o == 3'h7) [*2])
        else $error("lowest priority input not seven after word one");
    w1_mode_a: assert property (w1_wr |=> level_mode_o == $past(wr_data_i[3])
        && !init_done_o)
        else $error("trigger mode or restart wrong after word one");
    no_w4_a: assert property (w1_wr && !wr_data_i[0] |=> !auto_eoi_o)
        else $error("auto end of service set without word four");
    // ==================================================
    // Special mask follows its select only when enabled
    smm_set_a: assert property (c3_wr && wr_data_i[6]
        |=> special_mask_o == $past(wr_data_i[5]))
        else $error("special mask not taken from control word");
    smm_keep_a: assert property (c3_wr && !wr_data_i[6] |=> $stable(special_mask_o))
        else $error("special mask changed while not enabled");
    // ==================================================
    // Alert raised by word two, cleared by its readback
    alert_w2_a: assert property (w2_written_o |-> init_alert_o)
        else $error("word two write without alert");
    alert_ext_a: assert property (alert_set_i |=> init_alert_o)
        else $error("alert from another bank not raised");
    alert_clr_a: assert property (w2_rd |=> !init_alert_o && w2_read_o)
        else $error("word two readback did not clear alert");
    // ==================================================
    // Read port: unmapped offsets read zero, data holds between reads
    unmapped_read_a: assert property (rd_i && !ack_i && addr_i inside {[4'h3:4'h7]}
        |=> rd_data_o == 8'h00)
        else $error("unmapped offset read not zero");
    rd_hold_a: assert property (!rd_i && !ack_i |=> $stable(rd_data_o))
        else $error("read data moved without a read");
endmodule  // ibp_bank_sva
`default_nettype wire

/* test/ibp_host_model.sv */
`default_nettype none
// ==================================================
// Host processor model: byte writes, reads and acknowledges
module ibp_host_model (
    input  wire logic       ref_clk_i,
    output logic      [3:0] addr_o,
    output logic            wr_o,
    output logic            rd_o,
    output logic      [7:0] data_o,
    output logic            ack_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] exp_q[$];  // Expected results, oldest first

    // Idle bus at time zero
    initial begin
        addr_o = 4'h0;
        wr_o   = 1'b0;
        rd_o   = 1'b0;
        data_o = 8'h00;
        ack_o  = 1'b0;
    end

    // Strobes change on falling edges so the rising edge samples them settled
    task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge ref_clk_i);
        addr_o = a;
        data_o = d;
        wr_o   = 1'b1;
        @(negedge ref_clk_i);
        wr_o   = 1'b0;
        data_o = ~d;  // Released data must not look valid
    endtask

    task automatic bus_rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(negedge ref_clk_i);
        addr_o = a;
        rd_o   = 1'b1;
        @(negedge ref_clk_i);
        rd_o = 1'b0;
    endtask

    task automatic ack(input logic [7:0] e);
        exp_q.push_back(e);
        @(negedge ref_clk_i);
        ack_o = 1'b1;
        @(negedge ref_clk_i);
        ack_o = 1'b0;
    endtask

    // Whole sequence every time; word two read straight back so no handler is needed
    task automatic init_seq(input logic [7:0] w1, w2, w3, w4);
        bus_wr(ibp_pkg::OFS_CMD, w1);
        bus_wr(ibp_pkg::OFS_DATA, w2);
        bus_rd(ibp_pkg::OFS_W2_READ, w2);
        if (!w1[ibp_pkg::BIT_W1_SINGLE]) bus_wr(ibp_pkg::OFS_DATA, w3);
        if (w1[ibp_pkg::BIT_W1_W4]) bus_wr(ibp_pkg::OFS_DATA, w4);
    endtask
endmodule  // ibp_host_model
`default_nettype wire

/* test/interrupt_bank_programming_bench.sv */
`default_nettype none
// ==================================================
// Self-checking bench for one interrupt bank
module interrupt_bank_programming_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic       ref_clk_i, rst_i, wr, rd, ack, aset, aclr, rd_seen, int_w, alert, w2w, w2r;
    logic       done, lvl, auto_end_of_service, nest, special_mask_select;
    logic [3:0] addr;
    logic [7:0] wdata, req_n, rd_data, casc, vec[8], m;
    logic [2:0] prio;
    int         seed, bad_count, check_count;
    logic [7:0] smm_w[5] = '{8'h68, 8'h08, 8'h48, 8'h28, 8'h68};
    logic [7:0] smm_e[5] = '{8'h01, 8'h01, 8'h00, 8'h00, 8'h01};

    ibp_host_model u_ibp_host_model (.ref_clk_i(ref_clk_i), .addr_o(addr), .wr_o(wr),
        .rd_o(rd), .data_o(wdata), .ack_o(ack));
    ibp_bank u_ibp_bank (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr), .wr_i(wr),
        .rd_i(rd), .wr_data_i(wdata), .req_n_i(req_n), .ack_i(ack), .alert_set_i(aset),
        .alert_clr_i(aclr), .rd_data_o(rd_data), .int_o(int_w), .init_alert_o(alert),
        .w2_written_o(w2w), .w2_read_o(w2r), .init_done_o(done), .level_mode_o(lvl),
        .auto_eoi_o(auto_end_of_service), .nested_o(nest), .special_mask_o(special_mask_select), .cascade_o(casc),
        .lowest_prio_o(prio));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Clock and hang guard
    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        bad_count++;
        summarize();
    end

    // Results land one edge after the strobe; take the oldest note at the next falling edge
    always @(posedge ref_clk_i) rd_seen <= rd | ack;
    always @(negedge ref_clk_i) begin
        if (rd_seen === 1'b1) begin
            if (u_ibp_host_model.exp_q.size() == 0) begin
                check("unexpected result", 8'h01, 8'h00);
            end else begin
                check("rd_data", rd_data, u_ibp_host_model.exp_q.pop_front());
            end
        end
    end

    // Falling-edge pulse on a sideband alert input
    task automatic pulse(input logic clr);
        @(negedge ref_clk_i);
        aclr = clr;
        aset = !clr;
        @(negedge ref_clk_i);
        aclr = 1'b0;
        aset = 1'b0;
    endtask

    initial begin
        seed = 82317;
        rd_seen = 1'b0;
        rst_i = 1'b1;
        req_n = 8'hFF;
        aset = 1'b0;
        aclr = 1'b0;
        repeat (20) @(negedge ref_clk_i);
        rst_i = 1'b0;
        check("lowest_prio", 8'(prio), 8'h07);
        // Vectors go in before any init word so the alert has a handler entry
        for (int i = 0; i < 8; i++) begin
            vec[i] = 8'($random(seed));
            u_ibp_host_model.bus_wr(ibp_pkg::OFS_VEC_BASE + 4'(i), vec[i]);
        end
        for (int i = 0; i < 8; i++) begin
            u_ibp_host_model.bus_rd(ibp_pkg::OFS_VEC_BASE + 4'(i), vec[i]);
        end
        u_ibp_host_model.bus_rd(4'h3, 8'h00);
        check("init_done", 8'(done), 8'h00);
        // Half a sequence, then a sideband alert clear and a sideband alert set, then a full restart
        u_ibp_host_model.bus_wr(ibp_pkg::OFS_CMD, 8'h11);
        u_ibp_host_model.bus_wr(ibp_pkg::OFS_DATA, 8'h5A);
        check("alert", 8'(alert), 8'h01);
        pulse(1'b1);
        check("alert", 8'(alert), 8'h00);
        pulse(1'b0);
        u_ibp_host_model.init_seq(8'h11, 8'h3C, 8'hA5, 8'h12);
        check("cascade", casc, 8'hA5);
        check("modes", {4'h0, done, auto_end_of_service, nest, alert}, 8'h0E);
        // Mask mirror, then a write to the read-only word-two offset
        m = 8'($random(seed));
        u_ibp_host_model.bus_wr(ibp_pkg::OFS_DATA, m);
        u_ibp_host_model.bus_rd(ibp_pkg::OFS_DATA, m);
        u_ibp_host_model.bus_wr(ibp_pkg::OFS_W2_READ, 8'hFF);
        u_ibp_host_model.bus_rd(ibp_pkg::OFS_W2_READ, 8'h3C);
        foreach (smm_w[k]) begin
            u_ibp_host_model.bus_wr(ibp_pkg::OFS_CMD, smm_w[k]);
            check("special_mask", 8'(special_mask_select), smm_e[k]);
        end
        // Edge mode, single bank, no word four
        u_ibp_host_model.init_seq(8'h12, 8'h77, 8'h00, 8'h00);
        check("after word one", {3'h0, special_mask_select, auto_end_of_service, lvl, done, alert}, 8'h02);
        u_ibp_host_model.bus_rd(ibp_pkg::OFS_DATA, 8'h00);
        @(negedge ref_clk_i);
        req_n = 8'hDB;
        repeat (2) @(negedge ref_clk_i);
        u_ibp_host_model.bus_wr(ibp_pkg::OFS_CMD, 8'h0A);
        u_ibp_host_model.bus_rd(ibp_pkg::OFS_CMD, 8'h24);
        u_ibp_host_model.bus_rd(ibp_pkg::OFS_CMD, 8'h24);
        check("int", 8'(int_w), 8'h01);
        u_ibp_host_model.bus_wr(ibp_pkg::OFS_CMD, 8'h0E);
        u_ibp_host_model.bus_rd(ibp_pkg::OFS_CMD, 8'h82);
        u_ibp_host_model.bus_rd(ibp_pkg::OFS_CMD, 8'h24);
        u_ibp_host_model.bus_wr(ibp_pkg::OFS_CMD, 8'h0B);
        u_ibp_host_model.bus_rd(ibp_pkg::OFS_CMD, 8'h04);
        u_ibp_host_model.bus_wr(ibp_pkg::OFS_CMD, 8'h20);
        u_ibp_host_model.bus_rd(ibp_pkg::OFS_CMD, 8'h00);
        u_ibp_host_model.ack(vec[2]);
        u_ibp_host_model.bus_rd(ibp_pkg::OFS_CMD, 8'h04);
        // Pins still low after word one must not count until they fall again
        u_ibp_host_model.init_seq(8'h12, 8'h77, 8'h00, 8'h00);
        u_ibp_host_model.bus_rd(ibp_pkg::OFS_CMD, 8'h00);
        @(negedge ref_clk_i);
        req_n = 8'hFF;
        repeat (2) @(negedge ref_clk_i);
        req_n = 8'hDF;
        repeat (2) @(negedge ref_clk_i);
        u_ibp_host_model.bus_rd(ibp_pkg::OFS_CMD, 8'h20);
        u_ibp_host_model.init_seq(8'h1A, 8'h77, 8'h00, 8'h00);
        check("level_mode", 8'(lvl), 8'h01);
        repeat (4) @(negedge ref_clk_i);
        check("pending notes left", 8'(u_ibp_host_model.exp_q.size()), 8'h00);
        summarize();
    end
endmodule  // interrupt_bank_programming_bench

bind ibp_bank ibp_bank_sva u_sva (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wr_i(wr_i), .rd_i(rd_i), .wr_data_i(wr_data_i), .ack_i(ack_i),
    .alert_set_i(alert_set_i), .rd_data_o(rd_data_o), .init_alert_o(init_alert_o),
    .w2_written_o(w2_written_o), .w2_read_o(w2_read_o), .init_done_o(init_done_o),
    .level_mode_o(level_mode_o), .auto_eoi_o(auto_eoi_o), .special_mask_o(special_mask_o),
    .lowest_prio_o(lowest_prio_o));
`default_nettype wire
